// ---- rtl/instr_exec.sv ----
// execution of the skip-if-zero test and the table-write pointer update
`timescale 1ns/10ps
module instr_exec
    import instr_exec_pkg::*;
(
    input  wire logic                 mclk_in,
    input  wire logic                 rstn_in,
    input  wire skip_req_s            skip_req_in,
    input  wire logic                 ext_en_in,
    input  wire logic [BANK_W-1:0]    bank_select_register_in,
    input  wire logic [DADDR_W-1:0]   index_base_in,
    input  wire logic [DATA_W-1:0]    rdata_in,
    input  wire logic                 next_two_word_in,
    input  wire tw_req_s              tw_req_in,
    input  wire logic [DATA_W-1:0]    table_latch_in,
    input  wire logic                 ptr_load_in,
    input  wire logic [PTR_W-1:0]     ptr_load_val_in,
    output dmem_req_s                 dmem_req_out,
    output logic                      busy_out,
    output logic                      flush_out,
    output logic                      skip_done_out,
    output logic [PTR_W-1:0]          table_pointer_out,
    output logic [HOLD_COUNT*DATA_W-1:0] holding_out,
    output logic                      tw_done_out
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TEST = 2'b01,
        ST_SKIP = 2'b10
    } skip_st_e;

    typedef struct packed {
        skip_st_e                         st;
        logic [1:0]                       skip_left;
        dmem_req_s                        dmem;
        logic                             busy;
        logic                             flush;
        logic                             skip_done;
        logic [PTR_W-1:0]                 ptr;
        logic [HOLD_COUNT-1:0][DATA_W-1:0] hold;
        logic                             tw_done;
    } state_s;

    state_s             cur;
    state_s             next_cur;
    addr_mode_e         res_mode;
    logic [DADDR_W-1:0] res_addr;

    // select bits must reach exactly the holding array, and the pointer must carry them
    if (HOLD_COUNT != (1 << HOLD_SEL_W) || PTR_W < HOLD_SEL_W) begin : g_size_chk
        $error("holding array and select width disagree");
    end
    // banked and access addresses are concatenations, so the widths must add up
    if (DADDR_W != BANK_W + FADDR_W) begin : g_addr_chk
        $error("data address width is not bank plus operand width");
    end

    skip_addr_resolve u_resolve (
        .f_in          (skip_req_in.f),
        .a_in          (skip_req_in.a),
        .ext_en_in     (ext_en_in),
        .bank_in       (bank_select_register_in),
        .index_base_in (index_base_in),
        .mode_out      (res_mode),
        .addr_out      (res_addr)
    );

    always_comb begin
        logic [PTR_W-1:0] wptr;
        wptr = cur.ptr;
        next_cur = cur;
        next_cur.skip_done = 1'b0;
        next_cur.tw_done = 1'b0;
        next_cur.flush = 1'b0;
        next_cur.dmem.valid = 1'b0;
        unique case (cur.st)
            ST_IDLE: begin
                if (skip_req_in.valid) begin
                    next_cur.dmem = '{valid: 1'b1, mode: res_mode, addr: res_addr};
                    next_cur.st = ST_TEST;
                    next_cur.busy = 1'b1;
                end
            end
            ST_TEST: begin
                if (rdata_in != '0) begin
                    next_cur.st = ST_IDLE;
                    next_cur.busy = 1'b0;
                    next_cur.skip_done = 1'b1;
                end else begin
                    next_cur.st = ST_SKIP;
                    next_cur.flush = 1'b1;
                    next_cur.skip_left = next_two_word_in ? SKIP_TWO : SKIP_ONE;
                end
            end
            ST_SKIP: begin
                next_cur.flush = 1'b1;
                next_cur.skip_left = cur.skip_left - SKIP_ONE;
                if (cur.skip_left == SKIP_ONE) begin
                    next_cur.st = ST_IDLE;
                    next_cur.busy = 1'b0;
                    next_cur.flush = 1'b0;
                    next_cur.skip_done = 1'b1;
                end
            end
            default: next_cur.st = ST_IDLE;
        endcase
        // no status flag is touched by the skip
        if (ptr_load_in) begin
            next_cur.ptr = ptr_load_val_in;
        end else if (tw_req_in.valid) begin
            unique case (tw_req_in.mode)
                TW_NOCHG:   wptr = cur.ptr;
                TW_POSTINC: begin
                    wptr = cur.ptr;
                    next_cur.ptr = cur.ptr + PTR_W'(1);
                end
                TW_POSTDEC: begin
                    wptr = cur.ptr;
                    next_cur.ptr = cur.ptr - PTR_W'(1);
                end
                TW_PREINC:  begin
                    wptr = cur.ptr + PTR_W'(1);
                    next_cur.ptr = wptr;
                end
            endcase
            // latch is an input only, never written back
            next_cur.hold[wptr[HOLD_SEL_W-1:0]] = table_latch_in;
            next_cur.tw_done = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cur <= '{st: ST_IDLE, dmem: '{valid: 1'b0, mode: ADDR_ACCESS, addr: '0},
                     default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign dmem_req_out      = cur.dmem;
    assign busy_out          = cur.busy;
    assign flush_out         = cur.flush;
    assign skip_done_out     = cur.skip_done;
    assign table_pointer_out = cur.ptr;
    assign holding_out       = cur.hold;
    assign tw_done_out       = cur.tw_done;

    sequence s_zero_test;
        cur.st == ST_TEST && rdata_in == '0;
    endsequence

    // skip-test sequencing and operand addressing
    a_skip_take: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cur.st == ST_IDLE && skip_req_in.valid |=> busy_out && dmem_req_out.valid)
        else $error("skip request not taken");
    a_flush_with_busy: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        flush_out |-> busy_out)
        else $error("discard cycle outside a skip");
    a_skip_nonzero_done: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cur.st == ST_TEST && rdata_in != '0 |=> skip_done_out && !flush_out)
        else $error("nonzero test did not finish in one cycle");
    a_skip_one_word: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (s_zero_test and !next_two_word_in) |=> flush_out ##1 skip_done_out && !busy_out)
        else $error("single-word skip wrong length");
    a_skip_two_word: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (s_zero_test and next_two_word_in) |=> flush_out [*2] ##1 skip_done_out)
        else $error("two-word skip wrong length");
    a_indexed_mode: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cur.st == ST_IDLE && skip_req_in.valid && !skip_req_in.a && ext_en_in
        && skip_req_in.f <= INDEXED_MAX |=> dmem_req_out.mode == ADDR_INDEXED)
        else $error("indexed addressing not selected");
    a_indexed_excl: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cur.st == ST_IDLE && skip_req_in.valid && !ext_en_in
        |=> dmem_req_out.mode != ADDR_INDEXED)
        else $error("indexed path without extended set");
    a_bank_mode: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cur.st == ST_IDLE && skip_req_in.valid && skip_req_in.a
        |=> dmem_req_out.addr == {$past(bank_select_register_in), $past(skip_req_in.f)})
        else $error("banked address wrong");
    a_access_bank: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cur.st == ST_IDLE && skip_req_in.valid && !skip_req_in.a && !ext_en_in
        |=> dmem_req_out.mode == ADDR_ACCESS
        && dmem_req_out.addr[FADDR_W-1:0] == $past(skip_req_in.f))
        else $error("access bank address wrong");
    // table-write pointer and holding updates
    a_ptr_load_wins: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        ptr_load_in |=> table_pointer_out == $past(ptr_load_val_in) && !tw_done_out)
        else $error("pointer load did not take priority");
    a_post_inc: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        tw_req_in.valid && !ptr_load_in && tw_req_in.mode == TW_POSTINC
        |=> table_pointer_out == $past(table_pointer_out) + PTR_W'(1)
        && holding_out[$past(table_pointer_out[HOLD_SEL_W-1:0])*DATA_W +: DATA_W]
        == $past(table_latch_in))
        else $error("post-increment write wrong");
    a_pre_inc: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        tw_req_in.valid && !ptr_load_in && tw_req_in.mode == TW_PREINC
        |=> table_pointer_out == $past(table_pointer_out) + PTR_W'(1)
        && holding_out[table_pointer_out[HOLD_SEL_W-1:0]*DATA_W +: DATA_W]
        == $past(table_latch_in) && tw_done_out)
        else $error("pre-increment write wrong");
    a_pre_keeps_old: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        tw_req_in.valid && !ptr_load_in && tw_req_in.mode == TW_PREINC
        |=> holding_out[$past(table_pointer_out[HOLD_SEL_W-1:0])*DATA_W +: DATA_W]
        == $past(holding_out[table_pointer_out[HOLD_SEL_W-1:0]*DATA_W +: DATA_W]))
        else $error("pre-increment touched the old address");
    a_nochg_ptr: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        tw_req_in.valid && !ptr_load_in && tw_req_in.mode == TW_NOCHG
        |=> $stable(table_pointer_out))
        else $error("pointer moved without mode");
endmodule // instr_exec

// ---- common/instr_exec_pkg.sv ----
// shared constants and carriers for the skip-test and table-write execution block
package instr_exec_pkg;
    localparam int          PTR_W        = 21;
    localparam int          HOLD_SEL_W   = 3;
    localparam int          HOLD_COUNT   = 8;
    localparam int          DATA_W       = 8;
    localparam int          FADDR_W      = 8;
    localparam int          BANK_W       = 4;
    localparam int          DADDR_W      = 12;
    localparam logic [7:0]  INDEXED_MAX  = 8'h5F;
    localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
    localparam logic [3:0]  ACCESS_HI    = 4'hF;
    localparam logic [1:0]  SKIP_ONE     = 2'h1;
    localparam logic [1:0]  SKIP_TWO     = 2'h2;

    // pointer update modes as carried in the low two opcode bits
    typedef enum logic [1:0] {
        TW_NOCHG = 2'b00,
        TW_POSTINC = 2'b01,
        TW_POSTDEC = 2'b10,
        TW_PREINC = 2'b11
    } tw_mode_e;

    typedef enum logic [1:0] {
        ADDR_ACCESS = 2'b00,
        ADDR_BANKED = 2'b01,
        ADDR_INDEXED = 2'b10
    } addr_mode_e;

    // skip-test request from decode
    typedef struct packed {
        logic                 valid;
        logic [FADDR_W-1:0]   f;
        logic                 a;
    } skip_req_s;

    // resolved data-memory address
    typedef struct packed {
        logic                 valid;
        addr_mode_e           mode;
        logic [DADDR_W-1:0]   addr;
    } dmem_req_s;

    typedef struct packed {
        logic                 valid;
        tw_mode_e             mode;
    } tw_req_s;
endpackage

// ---- rtl/skip_addr_resolve.sv ----
// data address resolution for the skip-test operand
`timescale 1ns/10ps
module skip_addr_resolve
    import instr_exec_pkg::*;
(
    input  wire logic [FADDR_W-1:0] f_in,
    input  wire logic               a_in,
    input  wire logic               ext_en_in,
    input  wire logic [BANK_W-1:0]  bank_in,
    input  wire logic [DADDR_W-1:0] index_base_in,
    output addr_mode_e              mode_out,
    output logic [DADDR_W-1:0]      addr_out
);
    always_comb begin
        if (!a_in && ext_en_in && f_in <= INDEXED_MAX) begin
            mode_out = ADDR_INDEXED;
            addr_out = index_base_in + DADDR_W'(f_in);
        end else if (!a_in) begin
            mode_out = ADDR_ACCESS;
            addr_out = (f_in < ACCESS_SPLIT) ? {4'h0, f_in} : {ACCESS_HI, f_in};
        end else begin
            mode_out = ADDR_BANKED;
            addr_out = {bank_in, f_in};
        end
    end
endmodule // skip_addr_resolve

// ---- test/dmem_model.sv ----
// data memory stand-in answering the skip-test operand read
`timescale 1ns/10ps
module dmem_model
    import instr_exec_pkg::*;
(
    input  wire logic         mclk_in,
    input  wire dmem_req_s    req_in,
    output logic [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0]  mem [4096];
    logic [DADDR_W-1:0] last_addr;
    logic               last_valid = 1'b0;
    logic [DATA_W-1:0]  junk = 8'h5A;
    always @(posedge mclk_in) begin
        last_valid <= req_in.valid;
        last_addr <= req_in.addr;
        junk <= junk + 8'h3B;
    end
    // byte shown only while asked and one cycle on; churns otherwise so stale data never passes
    assign rdata_out = req_in.valid ? mem[req_in.addr] : (last_valid ? mem[last_addr] : junk);
endmodule // dmem_model

// ---- test/tb.sv ----
// self-checking bench for the skip-test and table-write execution block
`timescale 1ns/10ps
module tb;
    import instr_exec_pkg::*;
    logic                         mclk_in, rstn_in = 1'b0;
    logic                         ext_en_in = 1'b0, next_two_word_in = 1'b0, ptr_load_in = 1'b0;
    skip_req_s                    skip_req_in = '0;
    tw_req_s                      tw_req_in = '0;
    logic [BANK_W-1:0]            bank = 4'h0;
    logic [DADDR_W-1:0]           base = 12'h000;
    logic [DATA_W-1:0]            rdata, latch = 8'h00;
    logic [PTR_W-1:0]             ptr_val = '0, ptr;
    dmem_req_s                    dreq;
    logic                         busy, flush, skip_done, tw_done;
    logic [HOLD_COUNT*DATA_W-1:0] hold, hold_exp = '0;
    int                           fail_count, checks, cyc;

    instr_exec u_instr_exec (.mclk_in, .rstn_in, .skip_req_in, .ext_en_in,
        .bank_select_register_in(bank), .index_base_in(base), .rdata_in(rdata),
        .next_two_word_in, .tw_req_in, .table_latch_in(latch), .ptr_load_in,
        .ptr_load_val_in(ptr_val), .dmem_req_out(dreq), .busy_out(busy), .flush_out(flush),
        .skip_done_out(skip_done), .table_pointer_out(ptr), .holding_out(hold),
        .tw_done_out(tw_done));
    dmem_model u_dmem_model (.mclk_in, .req_in(dreq), .rdata_out(rdata));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        if (fail_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one skip test; flushes and cycles to completion counted from the taking edge
    task automatic run_skip(input logic [7:0] f, input logic a, input logic ext, input logic two,
            input logic [7:0] val, input addr_mode_e mode, input logic [11:0] addr, input int nfl);
        int n;
        int fl;
        n = 0;
        fl = 0;
        u_dmem_model.mem[addr] = val;
        @(posedge mclk_in);
        #1;
        ext_en_in = ext;
        next_two_word_in = two;
        skip_req_in = {1'b1, f, a};
        @(posedge mclk_in);
        #1;
        skip_req_in = '0;
        chk(dreq.valid, 1'b1);
        chk(dreq.mode, mode);
        chk(dreq.addr, addr);
        chk(busy, 1'b1);
        while (skip_done !== 1'b1 && n < 8) begin
            fl += (flush === 1'b1);
            @(posedge mclk_in);
            #1;
            n++;
        end
        chk(fl, nfl);
        chk(n, nfl + 1);
        chk(busy, 1'b0);
        chk(flush, 1'b0);
    endtask

    task automatic test_skip_banked;
        bank = 4'h5;
        run_skip(8'h23, 1'b1, 1'b0, 1'b0, 8'h07, ADDR_BANKED, 12'h523, 0);
        run_skip(8'h23, 1'b1, 1'b0, 1'b0, 8'h00, ADDR_BANKED, 12'h523, 1);
        run_skip(8'h23, 1'b1, 1'b0, 1'b1, 8'h00, ADDR_BANKED, 12'h523, 2);
    endtask

    task automatic test_skip_indexed;
        base = 12'h180;
        run_skip(8'h5F, 1'b0, 1'b1, 1'b1, 8'h00, ADDR_INDEXED, 12'h1DF, 2);
        run_skip(8'h60, 1'b0, 1'b1, 1'b1, 8'h01, ADDR_ACCESS, 12'hF60, 0);
        run_skip(8'h10, 1'b0, 1'b0, 1'b0, 8'h00, ADDR_ACCESS, 12'h010, 1);
    endtask

    // load pointer, issue one write, compare pointer and every holding byte
    task automatic do_tw(input tw_mode_e mode, input logic [7:0] lat, input logic [20:0] p,
            input logic [20:0] exp_p, input logic [20:0] wr);
        @(posedge mclk_in);
        #1;
        ptr_load_in = 1'b1;
        ptr_val = p;
        @(posedge mclk_in);
        #1;
        ptr_load_in = 1'b0;
        latch = lat;
        tw_req_in = {1'b1, mode};
        @(posedge mclk_in);
        #1;
        tw_req_in = '0;
        hold_exp[wr[2:0]*8 +: 8] = lat;
        chk(tw_done, 1'b1);
        chk(ptr, exp_p);
        chk(hold, hold_exp);
    endtask

    task automatic test_tw_modes;
        do_tw(TW_POSTINC, 8'h55, 21'h00A356, 21'h00A357, 21'h00A356);
        do_tw(TW_PREINC, 8'h34, 21'h01389A, 21'h01389B, 21'h01389B);
        do_tw(TW_NOCHG, 8'hC1, 21'h000010, 21'h000010, 21'h000010);
        do_tw(TW_POSTDEC, 8'h9E, 21'h000001, 21'h000000, 21'h000001);
        do_tw(TW_POSTINC, 8'hA7, 21'h1FFFFF, 21'h000000, 21'h1FFFFF);
        do_tw(TW_PREINC, 8'h3C, 21'h1FFFFF, 21'h000000, 21'h000000);
    endtask

    // mid-run reset clears every output; a pointer load then beats a same-cycle write
    task automatic test_reset;
        do_tw(TW_NOCHG, 8'h11, 21'h0000A5, 21'h0000A5, 21'h0000A5);
        @(posedge mclk_in);
        #1;
        rstn_in = 1'b0;
        #1;
        chk(ptr, '0);
        chk(hold, '0);
        chk({busy, flush, skip_done, tw_done, dreq.valid}, '0);
        @(posedge mclk_in);
        #1;
        rstn_in = 1'b1;
        hold_exp = '0;
        ptr_load_in = 1'b1;
        ptr_val = 21'h000123;
        latch = 8'hEE;
        tw_req_in = {1'b1, TW_POSTINC};
        @(posedge mclk_in);
        #1;
        ptr_load_in = 1'b0;
        tw_req_in = '0;
        chk(tw_done, 1'b0);
        chk(ptr, 21'h000123);
        chk(hold, hold_exp);
        do_tw(TW_POSTINC, 8'h66, 21'h000002, 21'h000003, 21'h000002);
    endtask

    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    // whole run needs about 60 cycles; ceiling leaves wide margin
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge mclk_in);
        #1;
        rstn_in = 1'b1;
        test_skip_banked();
        test_skip_indexed();
        test_tw_modes();
        test_reset();
        give_verdict();
    end
endmodule // tb
